// [design/logic_cell_defines.svh]
// offsets, field positions, reset values and counts for the logic cluster
// assumes 32-bit apb data, one aligned word per register
`ifndef LOGIC_CELL_DEFINES_SVH
`define LOGIC_CELL_DEFINES_SVH

`define APB_ADDR_W 12
`define CELL_CFG_BASE 12'h000
`define STATUS_OFFSET 12'h040
`define CFG_LUT_LSB 0
`define CFG_LUT_W 16
`define CFG_ARITH_BIT 16
`define CFG_CARRY_LUT_BIT 17
`define CFG_LUT_CHAIN_BIT 18
`define CFG_CLK_SEL_BIT 19
`define CFG_CLR_SEL_BIT 20
`define CFG_PRESET_BIT 21
`define CFG_REG_SRC_LSB 22
`define CFG_CHAIN_START_BIT 24
`define CFG_CHAIN_END_BIT 25
`define CFG_WR_MASK 32'h03ff_ffff
`define CFG_RESET 32'h0000_0000
`define STATUS_CARRY_BIT 16
`define CLUSTER_CELLS 10
`define CARRY_SECTION 5
`define MAX_CELLS 16

`endif

// [design/logic_cell_pkg.sv]
// types used by the logic cluster
// assumes the defines header supplies every number
package logic_cell_pkg;

    typedef enum logic [1:0] {
        REG_SRC_TABLE = 2'h0,
        REG_SRC_CHAIN = 2'h1,
        REG_SRC_DIRECT = 2'h2
    } reg_src_t;

    typedef enum logic {
        MODE_GENERAL = 1'h0,
        MODE_ARITH = 1'h1
    } cell_mode_t;

endpackage : logic_cell_pkg

// [design/logic_cell_carry_select.sv]
// a cluster of logic cells with carry-select chains and per-cell registers
// assumes apb master on pclk; all cluster and cell inputs synchronous to pclk
//
// What this block does
// [RULE1] each cell runs general or arithmetic mode, steering its eight inputs
// [RULE2] cluster signals give clock, enable, clears, preset/load, sync clear, sync load
// [RULE3] add/subtract acts in arithmetic mode; general mode only at chain end
// [RULE4] general mode: four inputs feed a 4-input table; one input carry or fourth
// [RULE5] general mode: table output passes on the lookup chain to the next cell
// [RULE6] asynchronous load value comes from the fourth data input
// [RULE7] register and table may serve unrelated functions on separate outputs
// [RULE8] arithmetic mode: two sum tables and two carry tables from first two inputs
// [RULE9] cluster carry-in picks a chain; its level picks the precomputed sum
// [RULE10] zero chain carry picks zero carry-out, one chain carry picks one carry-out
// [RULE11] arithmetic mode gives both registered and unregistered sum
// [RULE12] counter enable and up/down come from data inputs, act at clock edge
// [RULE13] sync clear and sync load act on all cluster registers together
// [RULE14] add/subtract drives carry input of the first chain cell only
// [RULE15] a carry chain may start at any cell
// [RULE16] chain select regenerated at fifth and tenth cells; final carry routed out
// [RULE17] chains continue across clusters by linking carry-out to next carry-in
// [RULE18] preset is an asynchronous load of one, no inversion
// [RULE19] clear wins over preset/load when both are asserted
// [RULE20] at most two async clears and one async preset per cluster
// [RULE21] optional active-low device-wide clear resets all, overrides everything
// [RULE22] subtraction inverts second operand and forces chain carry-in to one
// [RULE23] each cluster clock paired with its enable; enable low stops that clock
// [RULE24] register updates on selected clock edge only while paired enable is high
`timescale 1ns/1ps
`include "logic_cell_defines.svh"

module logic_cell_carry_select #(
    parameter int CELLS = `CLUSTER_CELLS,
    parameter int SECTION = `CARRY_SECTION,
    parameter bit DEV_CLEAR_EN = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`APB_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [CELLS-1:0] data_a,
    input wire logic [CELLS-1:0] data_b,
    input wire logic [CELLS-1:0] data_c,
    input wire logic [CELLS-1:0] fourth_data_input,
    input wire logic cluster_carry_in,
    input wire logic zero_chain_carry_in,
    input wire logic one_chain_carry_in,
    input wire logic lut_chain_in,
    input wire logic reg_chain_in,
    input wire logic cluster_clock_a,
    input wire logic cluster_clock_b,
    input wire logic cluster_clock_enable_a,
    input wire logic cluster_clock_enable_b,
    input wire logic async_clear_a,
    input wire logic async_clear_b,
    input wire logic async_preset_load,
    input wire logic sync_clear,
    input wire logic sync_load,
    input wire logic add_sub,
    input wire logic device_wide_clear_n,
    output logic [CELLS-1:0] comb_out,
    output logic [CELLS-1:0] reg_out,
    output logic cluster_carry_out,
    output logic zero_chain_carry_out,
    output logic one_chain_carry_out,
    output logic lut_chain_out,
    output logic reg_chain_out
);

    generate
        if (CELLS < 1 || CELLS > `MAX_CELLS || SECTION < 1 || (CELLS % SECTION) != 0) begin : g_bad_size
            $error("cell count must be 1..16 and a multiple of the section length");
        end
    endgenerate

    function automatic logic table4(input logic [15:0] mask, input logic [3:0] sel);
        table4 = mask[sel];
    endfunction : table4

    // carry table pair: generate when chain carry low, propagate when high
    function automatic logic carry_pick(input logic cin, input logic a, input logic b);
        carry_pick = cin ? (a | b) : (a & b);
    endfunction : carry_pick

    // configuration and register state
    logic [31:0] cfg_q [CELLS];
    logic [CELLS-1:0] reg_q;
    logic [CELLS-1:0] reg_d;
    logic clk_a_q;
    logic clk_b_q;

    // chain evaluation
    logic [CELLS-1:0] comb_v;
    logic [CELLS-1:0] sub_eff;
    logic c0;
    logic c1;
    logic sel;
    logic cin_sel;
    logic beff;
    logic lut_prev;
    logic ta;
    logic tb;
    logic td;
    logic dval;
    logic carry_sel_v;

    // cluster clock edges with paired enables, sampled on pclk
    wire logic edge_a = cluster_clock_a & ~clk_a_q;
    wire logic edge_b = cluster_clock_b & ~clk_b_q;
    wire logic tick_a = edge_a & cluster_clock_enable_a; // see [RULE23]
    wire logic tick_b = edge_b & cluster_clock_enable_b; // see [RULE23]
    wire logic dev_clear = DEV_CLEAR_EN & ~device_wide_clear_n;

    // apb decode
    wire logic [3:0] cell_idx = paddr[5:2];
    wire logic cell_hit = (paddr[`APB_ADDR_W-1:6] == '0) && (paddr[1:0] == 2'h0) && (32'(cell_idx) < CELLS);
    wire logic stat_hit = (paddr == `STATUS_OFFSET);
    wire logic apb_access = psel & penable & ~pready;
    wire logic apb_done = psel & penable & pready;
    wire logic cfg_wr = apb_done & pwrite & cell_hit;
    wire logic [31:0] status_w = 32'(reg_q) | (32'(cluster_carry_out) << `STATUS_CARRY_BIT);
    wire logic [31:0] rd_w = cell_hit ? cfg_q[cell_idx] : (stat_hit ? status_w : 32'h0);

    always_comb begin
        c0 = zero_chain_carry_in;
        c1 = one_chain_carry_in;
        sel = cluster_carry_in;
        lut_prev = lut_chain_in;
        cin_sel = 1'b0;
        beff = 1'b0;
        ta = 1'b0;
        tb = 1'b0;
        td = 1'b0;
        dval = 1'b0;
        comb_v = '0;
        sub_eff = '0;
        reg_d = reg_q;
        for (int i = 0; i < CELLS; i++) begin
            // chain select regenerated at each section boundary
            if (i != 0 && (i % SECTION) == 0) begin
                sel = sel ? c1 : c0; // see [RULE16]
                c0 = 1'b0;
                c1 = 1'b1;
            end
            // arithmetic: up/down flips the operand sense together with add/subtract
            if (cfg_q[i][`CFG_ARITH_BIT]) begin
                sub_eff[i] = add_sub ^ ~fourth_data_input[i]; // see [RULE3] see [RULE12]
            end else begin
                sub_eff[i] = add_sub & cfg_q[i][`CFG_CHAIN_END_BIT]; // see [RULE3]
            end
            if (cfg_q[i][`CFG_CHAIN_START_BIT]) begin
                c0 = sub_eff[i]; // see [RULE14] see [RULE15] see [RULE22]
                c1 = sub_eff[i];
            end
            cin_sel = sel ? c1 : c0; // see [RULE9]
            beff = data_b[i] ^ sub_eff[i]; // see [RULE22]
            if (cfg_q[i][`CFG_ARITH_BIT]) begin // see [RULE1]
                // two sum tables precomputed, chain level chooses one
                comb_v[i] = cin_sel ? ~(data_a[i] ^ beff) : (data_a[i] ^ beff); // see [RULE8] see [RULE9]
                dval = comb_v[i]; // see [RULE11]
            end else begin
                ta = cfg_q[i][`CFG_LUT_CHAIN_BIT] ? lut_prev : data_a[i]; // see [RULE5]
                tb = beff;
                td = cfg_q[i][`CFG_CARRY_LUT_BIT] ? cin_sel : fourth_data_input[i]; // see [RULE4]
                comb_v[i] = table4(cfg_q[i][`CFG_LUT_LSB +: `CFG_LUT_W], {td, data_c[i], tb, ta}); // see [RULE4]
                case (logic_cell_pkg::reg_src_t'(cfg_q[i][`CFG_REG_SRC_LSB +: 2]))
                    logic_cell_pkg::REG_SRC_CHAIN: dval = (i == 0) ? reg_chain_in : reg_q[(i == 0) ? 0 : i - 1];
                    logic_cell_pkg::REG_SRC_DIRECT: dval = data_c[i]; // see [RULE7]
                    default: dval = comb_v[i];
                endcase
            end
            // carry tables from first two inputs, each chain selects its own
            c0 = carry_pick(c0, data_a[i], beff); // see [RULE8] see [RULE10]
            c1 = carry_pick(c1, data_a[i], beff); // see [RULE10]
            lut_prev = comb_v[i];
            // register priority: device clear, async clear, async load, clocked
            if (dev_clear) begin
                reg_d[i] = 1'b0; // see [RULE21]
            end else if (cfg_q[i][`CFG_CLR_SEL_BIT] ? async_clear_b : async_clear_a) begin
                reg_d[i] = 1'b0; // see [RULE19] see [RULE20] see [RULE2]
            end else if (async_preset_load) begin
                reg_d[i] = cfg_q[i][`CFG_PRESET_BIT] ? 1'b1 : fourth_data_input[i]; // see [RULE6] see [RULE18]
            end else if (cfg_q[i][`CFG_CLK_SEL_BIT] ? tick_b : tick_a) begin // see [RULE24] see [RULE2]
                if (sync_clear) begin
                    reg_d[i] = 1'b0; // see [RULE13]
                end else if (sync_load) begin
                    reg_d[i] = fourth_data_input[i]; // see [RULE13]
                end else if (!cfg_q[i][`CFG_ARITH_BIT] || data_c[i]) begin
                    reg_d[i] = dval; // see [RULE12]
                end
            end
        end
        carry_sel_v = sel ? c1 : c0; // see [RULE16]
    end

    // clock samples for edge detection; async reset to constants only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_a_q <= 1'b0;
            clk_b_q <= 1'b0;
        end else begin
            clk_a_q <= cluster_clock_a;
            clk_b_q <= cluster_clock_b;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reg_q <= '0;
        end else begin
            reg_q <= reg_d;
        end
    end

    // combinational results leave through one flop stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            comb_out <= '0;
            reg_out <= '0;
            cluster_carry_out <= 1'b0;
            zero_chain_carry_out <= 1'b0;
            one_chain_carry_out <= 1'b0;
            lut_chain_out <= 1'b0;
            reg_chain_out <= 1'b0;
        end else begin
            comb_out <= comb_v; // see [RULE7] see [RULE11]
            reg_out <= reg_d;
            cluster_carry_out <= carry_sel_v; // see [RULE17]
            zero_chain_carry_out <= c0;
            one_chain_carry_out <= c1;
            lut_chain_out <= comb_v[CELLS-1]; // see [RULE5]
            reg_chain_out <= reg_d[CELLS-1];
        end
    end

    // apb: one wait cycle, then pready; write lands on the pready edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= apb_access;
            pslverr <= apb_access & ~cell_hit & ~stat_hit;
            prdata <= (apb_access && !pwrite) ? rd_w : 32'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < CELLS; i++) begin
                cfg_q[i] <= `CFG_RESET;
            end
        end else if (cfg_wr) begin
            cfg_q[cell_idx] <= pwdata & `CFG_WR_MASK;
        end
    end

endmodule : logic_cell_carry_select

// [testbench/logic_cell_assertions.sv]
// checker for the logic cluster: apb handshake and cell register controls
// assumes one pclk domain, bound onto the top module ports
`timescale 1ns/1ps
module logic_cell_assertions #(
    parameter int CELLS = 10
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic [CELLS-1:0] fourth_data_input,
    input wire logic cluster_clock_a,
    input wire logic cluster_clock_b,
    input wire logic cluster_clock_enable_a,
    input wire logic cluster_clock_enable_b,
    input wire logic async_clear_a,
    input wire logic async_clear_b,
    input wire logic async_preset_load,
    input wire logic sync_clear,
    input wire logic device_wide_clear_n,
    input wire logic [CELLS-1:0] reg_out
);
    wire logic no_async = device_wide_clear_n && !async_clear_a && !async_clear_b && !async_preset_load;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // two samples: async effects land one cycle late
    AST_DEV_CLEAR: assert property (!device_wide_clear_n [*2] |-> reg_out == '0)
        else $error("device clear left a register set");
    AST_CLEAR_WINS: assert property ((async_clear_a && async_clear_b && async_preset_load) [*2] |-> reg_out == '0)
        else $error("preset beat clear");
    AST_PRESET_LOAD: assert property ((device_wide_clear_n && !async_clear_a && !async_clear_b && async_preset_load
        && $stable(fourth_data_input)) [*2] |-> (fourth_data_input & ~reg_out) == '0)
        else $error("async load value wrong");
    AST_HOLD_NO_TICK: assert property ((no_async && !cluster_clock_a && !cluster_clock_b) [*3] |-> $stable(reg_out))
        else $error("register moved without a clock tick");
    AST_HOLD_ENA_LOW: assert property ((no_async && !cluster_clock_enable_a && !cluster_clock_enable_b) [*3]
        |-> $stable(reg_out))
        else $error("register moved with enables low");
    AST_SYNC_CLEAR: assert property (no_async && sync_clear && $rose(cluster_clock_a) && cluster_clock_enable_a
        && $rose(cluster_clock_b) && cluster_clock_enable_b |=> reg_out == '0)
        else $error("sync clear missed");
    AST_READY_LATENCY: assert property (psel && !penable |=> ##1 pready)
        else $error("pready not in second access cycle");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    cover property (sync_clear && $rose(cluster_clock_a));
    cover property (async_clear_a && async_preset_load);
    cover property (!device_wide_clear_n);
endmodule : logic_cell_assertions

bind logic_cell_carry_select logic_cell_assertions #(.CELLS(CELLS)) u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pready(pready), .fourth_data_input(fourth_data_input),
    .cluster_clock_a(cluster_clock_a), .cluster_clock_b(cluster_clock_b),
    .cluster_clock_enable_a(cluster_clock_enable_a), .cluster_clock_enable_b(cluster_clock_enable_b),
    .async_clear_a(async_clear_a), .async_clear_b(async_clear_b), .async_preset_load(async_preset_load),
    .sync_clear(sync_clear), .device_wide_clear_n(device_wide_clear_n), .reg_out(reg_out));

// [testbench/cluster_fabric_model.sv]
// fabric model: cluster clock lines, one pulse per request
// assumes requests arrive from the bench on pclk edges
`timescale 1ns/1ps
module cluster_fabric_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tick_req,
    output logic cluster_clock_a,
    output logic cluster_clock_b
);
    // lines stand low between ticks, never free running
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cluster_clock_a <= 1'b0;
            cluster_clock_b <= 1'b0;
        end else begin
            cluster_clock_a <= tick_req;
            cluster_clock_b <= tick_req;
        end
    end
endmodule : cluster_fabric_model

// [testbench/tb.sv]
// bench for the logic cluster: apb config, datapath and register controls
// assumes the fabric model drives both cluster clocks
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb;
    localparam int N = 10;
    localparam logic [9:0] av [4] = '{10'h3ff, 10'h155, 10'h200, 10'h005};
    localparam logic [9:0] bv [4] = '{10'h001, 10'h0aa, 10'h001, 10'h00a};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, tick_req, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [N-1:0] da, db, dc, d4, comb_out, reg_out;
    logic cin, clk_a, clk_b, ena, enb, clr_a, clr_b, pre, sclr, sload, add_sub, dcn, cco, lco, sub;
    logic [10:0] ex;
    logic c0o, c1o, rco;
    logic [9:0] bx;
    logic [5:0] e0, e1;
    int error_cnt = 0;
    int samples_checked = 0;
    cluster_fabric_model fab (.pclk(pclk), .presetn(presetn), .tick_req(tick_req), .cluster_clock_a(clk_a),
        .cluster_clock_b(clk_b));
    logic_cell_carry_select #(.CELLS(N)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .data_a(da), .data_b(db), .data_c(dc), .fourth_data_input(d4), .cluster_carry_in(cin),
        .zero_chain_carry_in(1'b0), .one_chain_carry_in(1'b0), .lut_chain_in(1'b0), .reg_chain_in(1'b0),
        .cluster_clock_a(clk_a), .cluster_clock_b(clk_b), .cluster_clock_enable_a(ena),
        .cluster_clock_enable_b(enb), .async_clear_a(clr_a), .async_clear_b(clr_b), .async_preset_load(pre),
        .sync_clear(sclr), .sync_load(sload), .add_sub(add_sub), .device_wide_clear_n(dcn),
        .comb_out(comb_out), .reg_out(reg_out), .cluster_carry_out(cco), .zero_chain_carry_out(c0o),
        .one_chain_carry_out(c1o), .lut_chain_out(lco), .reg_chain_out(rco));
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 8; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 8) begin
            error_cnt++;
            finish_test();
        end
    endtask : apb
    task automatic settle();
        repeat (4) @(posedge pclk);
    endtask : settle
    // one request gives one pulse on both cluster clocks
    task automatic tick();
        @(posedge pclk);
        tick_req <= 1'b1;
        @(posedge pclk);
        tick_req <= 1'b0;
        settle();
    endtask : tick
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        finish_test();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, tick_req, cin, clr_a, clr_b, pre, sclr, sload} = '0;
        {da, db, dc, d4, add_sub} = '0;
        {dcn, ena, enb} = 3'h7;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < N; i++) begin
            apb(1'b0, 12'(4 * i), 32'h0);
            `CHK("cfg reset", 32'h0, rd)
        end
        apb(1'b1, 12'h000, 32'hffff_ffff);
        apb(1'b0, 12'h000, 32'h0);
        `CHK("cfg mask", 32'h03ff_ffff, rd)
        apb(1'b0, 12'h044, 32'h0);
        `CHK("unmapped err", 1'b1, err)
        `CHK("unmapped data", 32'h0, rd)
        $display("test registers done");
        // general mode: table is a four-input and, add_sub must be ignored
        for (int i = 0; i < N; i++) apb(1'b1, 12'(4 * i), 32'h0000_8000);
        @(posedge pclk);
        {da, db, dc, d4} <= '1;
        add_sub <= 1'b1;
        tick();
        `CHK("table and", {N{1'b1}}, comb_out)
        `CHK("reg from table", {N{1'b1}}, reg_out)
        da <= '0;
        settle();
        `CHK("table zero", {N{1'b0}}, comb_out)
        `CHK("lut chain", 1'b0, lco)
        `CHK("reg packed", {N{1'b1}}, reg_out)
        `CHK("reg chain out", 1'b1, rco)
        $display("test general done");
        for (int i = 0; i < N; i++) apb(1'b1, 12'(4 * i), 32'h0001_0000 | (i == 0 ? 32'h0100_0000 : 32'h0)
            | (i == N - 1 ? 32'h0200_0000 : 32'h0));
        for (int k = 0; k < 4; k++) begin
            sub = (k >= 2);
            ex = {1'b0, av[k]} + {1'b0, sub ? ~bv[k] : bv[k]} + 11'(sub);
            bx = sub ? ~bv[k] : bv[k];
            e0 = {1'b0, av[k][9:5]} + {1'b0, bx[9:5]};
            e1 = e0 + 6'h1;
            @(posedge pclk);
            da <= av[k];
            db <= bv[k];
            add_sub <= sub;
            cin <= k[0];
            tick();
            `CHK("sum", ex[9:0], comb_out)
            `CHK("carry out", ex[10], cco)
            `CHK("zero chain out", e0[5], c0o)
            `CHK("one chain out", e1[5], c1o)
            `CHK("sum reg", ex[9:0], reg_out)
        end
        dc <= '0;
        da <= 10'h0f0;
        tick();
        `CHK("count off", ex[9:0], reg_out)
        $display("test arithmetic done");
        apb(1'b1, 12'h000, 32'h0020_0000);
        for (int i = 1; i < N; i++) apb(1'b1, 12'(4 * i), 32'h0);
        d4 <= 10'h0f0;
        pre <= 1'b1;
        settle();
        `CHK("async load", 10'h0f1, reg_out)
        {clr_a, clr_b} <= 2'h3;
        settle();
        `CHK("clear wins", 10'h000, reg_out)
        {clr_a, clr_b, pre} <= 3'h0;
        d4 <= 10'h2a5;
        sclr <= 1'b1;
        sload <= 1'b1;
        tick();
        `CHK("sync clear", 10'h000, reg_out)
        sclr <= 1'b0;
        tick();
        `CHK("sync load", 10'h2a5, reg_out)
        {ena, enb} <= 2'h0;
        d4 <= 10'h15a;
        tick();
        `CHK("enable low", 10'h2a5, reg_out)
        {ena, enb} <= 2'h3;
        tick();
        `CHK("enable high", 10'h15a, reg_out)
        dcn <= 1'b0;
        settle();
        `CHK("device clear", 10'h000, reg_out)
        $display("test controls done");
        // register sources: previous cell, then data_c directly
        dcn <= 1'b1;
        tick();
        `CHK("reload", 10'h15a, reg_out)
        sload <= 1'b0;
        for (int i = 0; i < N; i++) apb(1'b1, 12'(4 * i), 32'h0040_0000);
        tick();
        `CHK("reg chain shift", 10'h2b4, reg_out)
        for (int i = 0; i < N; i++) apb(1'b1, 12'(4 * i), 32'h0080_0000);
        dc <= 10'h0c3;
        tick();
        `CHK("reg direct", 10'h0c3, reg_out)
        $display("test sources done");
        finish_test();
    end
endmodule : tb
